// ==== bench/rtcac_alarm_ctrl_tb_top.sv ====
// self-checking bench of the clock alarm and control block
// assumes the block stands alone: this bench is bus master, count chain and wake source
module rtcac_alarm_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [rtcac_pkg::ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	rtcac_pkg::rtcac_count_t cnt = 32'h0, c;
	logic tick = 1'b0, wake = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, irq, pclr, osc, line, bcd, run, cwe;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic [15:0] div;
	logic [7:0] v, eh, es, ew, emn;
	logic [7:0] hv [6] = '{8'h17, 8'h18, 8'h29, 8'h2A, 8'h3B, 8'h3C};
	int bad_count = 0, total_checks = 0, clr_n = 0, n0, i, m;
	always #2 clk = ~clk;
	always @(posedge clk) if (pclr === 1'b1) clr_n <= clr_n + 1;
	rtcac_alarm_ctrl dut (.I_CLK(clk), .I_RST_N(rst_n), .I_AWVALID(awvalid), .O_AWREADY(awready),
		.I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb),
		.O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
		.I_COUNT(cnt), .I_COUNT_TICK(tick), .I_WAKE_BY_ALARM(wake), .O_ALARM_IRQ(irq),
		.O_PRESCALER_CLEAR(pclr), .O_OSC_ENABLE(osc), .O_LINE_SOURCE(line), .O_PRESCALE_DIVISOR(div),
		.O_BCD_MODE(bcd), .O_COUNTER_RUN(run), .O_COUNT_WRITE_ENABLE(cwe));
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, e);
		end
	endtask
	// ready is looked at on the falling edge, so the rising edge after it is the one that takes the item
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic s = 1'b1);
		logic ta, tw, ga, gw;
		ta = 1'b0;
		tw = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= {3'h0, s};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge clk);
			ga = awvalid & awready;
			gw = wvalid & wready;
			@(posedge clk);
			if (ga) begin
				awvalid <= 1'b0;
				ta = 1'b1;
			end
			if (gw) begin
				wvalid <= 1'b0;
				tw = 1'b1;
			end
		end
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ga = bvalid;
			rsp = bresp;
			@(posedge clk);
		end while (ga !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [11:0] a);
		logic g;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge clk);
			g = arready;
			@(posedge clk);
		end while (g !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			g = rvalid;
			rd = rdata;
			rsp = rresp;
			@(posedge clk);
		end while (g !== 1'b1);
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string s);
		rdr(a);
		chk(rd, {24'h0, e}, s);
		chk(rsp, rtcac_pkg::RESP_OKAY, "read response");
	endtask
	task automatic pulse(input rtcac_pkg::rtcac_count_t k, input logic t, input logic e, input string s);
		cnt <= k;
		tick <= t;
		@(posedge clk);
		tick <= 1'b0;
		@(negedge clk);
		chk(irq, e, s);
		@(posedge clk);
	endtask
	// legal set-point values in the current number format; h selects the hour limits
	function automatic logic okv(input logic [7:0] x, input logic b, input logic h);
		if (b)
			return x[3:0] <= 4'h9 && x[7:4] <= (h ? 4'h2 : 4'h5);
		return x <= (h ? 8'h17 : 8'h3B);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		bad_count++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		final_report();
	end
	initial begin
		rd = $urandom(32'h19CF);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		@(negedge clk);
		chk({run, cwe, irq}, 3'h4, "run, write enable, irq after reset");
		@(posedge clk);
		rdr(rtcac_pkg::ADDR_CONTROL);
		chk(rd & 32'h43, 32'h02, "control reset bits and woke");
		rdr(rtcac_pkg::ADDR_CONTROL);
		chk(rd & 32'h02, 32'h0, "woke cleared by read");
		rchk(rtcac_pkg::ADDR_FIELD_EN, 8'h00, "enables reset");
		// every source, line rate and dst combination
		for (i = 0; i < 8; i++) begin
			v = {2'h0, 1'($urandom), i[0], i[1], i[2], 2'h0};
			n0 = clr_n;
			wr(rtcac_pkg::ADDR_CONTROL, v);
			@(negedge clk);
			chk(clr_n, n0 + 1, "one prescaler clear per write");
			chk(div, i[0] ? (i[1] ? 16'h0032 : 16'h003C) : 16'h8000, "divisor");
			chk({osc, line, bcd}, {~i[0], i[0], v[5]}, "source and mode outputs");
			@(posedge clk);
			rdr(rtcac_pkg::ADDR_CONTROL);
			chk(rd & 32'h7D, {24'h0, v}, "control read back");
		end
		// set-point ranges in both number formats, corners then random
		for (m = 0; m < 2; m++) begin
			wr(rtcac_pkg::ADDR_CONTROL, {2'h0, m[0], 5'h0});
			wr(rtcac_pkg::ADDR_ALM_HOUR, 8'h01);
			wr(rtcac_pkg::ADDR_ALM_SECOND, 8'h01);
			wr(rtcac_pkg::ADDR_ALM_MINUTE, 8'h01);
			eh = 8'h01;
			es = 8'h01;
			emn = 8'h01;
			for (i = 0; i < 14; i++) begin
				v = (i < 6) ? hv[i] : 8'($urandom_range(63));
				wr(rtcac_pkg::ADDR_ALM_HOUR, v);
				if (okv(v, m[0], 1'b1)) eh = v;
				rchk(rtcac_pkg::ADDR_ALM_HOUR, eh, "hour set-point");
				wr(rtcac_pkg::ADDR_ALM_SECOND, v);
				if (okv(v, m[0], 1'b0)) es = v;
				rchk(rtcac_pkg::ADDR_ALM_SECOND, es, "second set-point");
				wr(rtcac_pkg::ADDR_ALM_MINUTE, v);
				if (okv(v, m[0], 1'b0)) emn = v;
				rchk(rtcac_pkg::ADDR_ALM_MINUTE, emn, "minute set-point");
			end
		end
		wr(rtcac_pkg::ADDR_ALM_HOUR, 8'h12);
		wr(rtcac_pkg::ADDR_ALM_HOUR, 8'h02, 1'b0);
		rchk(rtcac_pkg::ADDR_ALM_HOUR, 8'h12, "strobe low ignored");
		wr(12'h3B8, 8'h01);
		chk(rsp, rtcac_pkg::RESP_DECERR, "unmapped write");
		rdr(12'h3A9);
		chk(rsp, rtcac_pkg::RESP_DECERR, "misaligned read");
		// weekday: writable only while unlocked; upper nibble written as zero
		wr(rtcac_pkg::ADDR_CONTROL, 8'h21);
		@(negedge clk);
		chk({run, cwe}, 2'h1, "unlocked halts counter");
		@(posedge clk);
		wr(rtcac_pkg::ADDR_ALM_WEEKDAY, 8'h03);
		ew = 8'h03;
		wr(rtcac_pkg::ADDR_CONTROL, 8'h20);
		wr(rtcac_pkg::ADDR_ALM_WEEKDAY, 8'h05);
		rchk(rtcac_pkg::ADDR_ALM_WEEKDAY, ew, "weekday locked");
		wr(rtcac_pkg::ADDR_CONTROL, 8'h21);
		for (i = 0; i < 16; i++) begin
			wr(rtcac_pkg::ADDR_ALM_WEEKDAY, {4'h0, 4'(i)});
			if (i >= 1 && i <= 7) ew = 8'(i);
			rchk(rtcac_pkg::ADDR_ALM_WEEKDAY, ew, "weekday range");
		end
		wr(rtcac_pkg::ADDR_FIELD_EN, 8'h0F);
		chk(rsp, rtcac_pkg::RESP_OKAY, "write response");
		rchk(rtcac_pkg::ADDR_FIELD_EN, 8'h0F, "enables write");
		// reset in mid-run keeps set-points and clears enables
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(rtcac_pkg::ADDR_ALM_HOUR, 8'h12, "hour kept");
		rchk(rtcac_pkg::ADDR_ALM_WEEKDAY, ew, "weekday kept");
		rchk(rtcac_pkg::ADDR_FIELD_EN, 8'h00, "enables cleared");
		rdr(rtcac_pkg::ADDR_CONTROL);
		chk(rd & 32'h63, 32'h20, "control after second reset");
		// alarm on weekday, hour and second; minute disabled and mismatched
		wr(rtcac_pkg::ADDR_ALM_SECOND, 8'h10);
		wr(rtcac_pkg::ADDR_FIELD_EN, 8'h0D);
		wr(rtcac_pkg::ADDR_CONTROL, 8'h60);
		c = '{wday: ew, hour: 8'h12, min: 8'h77, sec: 8'h10};
		pulse(c, 1'b0, 1'b0, "no tick no alarm");
		pulse('{wday: ew, hour: 8'h13, min: 8'h77, sec: 8'h10}, 1'b1, 1'b0, "hour mismatch");
		pulse(c, 1'b1, 1'b1, "match raises irq");
		rdr(rtcac_pkg::ADDR_CONTROL);
		chk(rd[7], 1'b1, "flag seen");
		@(negedge clk);
		chk(irq, 1'b0, "read clears irq");
		@(posedge clk);
		wr(rtcac_pkg::ADDR_FIELD_EN, 8'h00);
		pulse(c, 1'b1, 1'b0, "no field enabled");
		wr(rtcac_pkg::ADDR_FIELD_EN, 8'h0F);
		pulse(c, 1'b1, 1'b0, "minute enabled, count differs");
		wr(rtcac_pkg::ADDR_FIELD_EN, 8'h0D);
		wr(rtcac_pkg::ADDR_CONTROL, 8'h20);
		pulse(c, 1'b1, 1'b0, "irq gated by enable");
		rdr(rtcac_pkg::ADDR_CONTROL);
		chk(rd[7], 1'b1, "flag without irq");
		wr(rtcac_pkg::ADDR_CONTROL, 8'h61);
		@(negedge clk);
		chk(irq, 1'b0, "unlock does not evaluate");
		@(posedge clk);
		wr(rtcac_pkg::ADDR_CONTROL, 8'h60);
		@(negedge clk);
		chk(irq, 1'b1, "relock evaluates");
		@(posedge clk);
		final_report();
	end
endmodule

// ==== core/rtcac_alarm_ctrl.sv ====
// alarm set-points, field enables and control/status register of the clock, axi4-lite slave
// assumes the count chain outside supplies counts, an increment tick and the wake cause at reset
module rtcac_alarm_ctrl (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [rtcac_pkg::ADDR_W-1:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [rtcac_pkg::ADDR_W-1:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	input wire rtcac_pkg::rtcac_count_t I_COUNT,
	input wire logic I_COUNT_TICK,
	input wire logic I_WAKE_BY_ALARM,
	output logic O_ALARM_IRQ,
	output logic O_PRESCALER_CLEAR,
	output logic O_OSC_ENABLE,
	output logic O_LINE_SOURCE,
	output logic [15:0] O_PRESCALE_DIVISOR,
	output logic O_BCD_MODE,
	output logic O_COUNTER_RUN,
	output logic O_COUNT_WRITE_ENABLE
);

	rtcac_pkg::rtcac_state_t s_q;
	rtcac_pkg::rtcac_state_t s_d;
	rtcac_pkg::rtcac_count_t set_pts;
	logic aw_rdy;
	logic w_rdy;
	logic ar_rdy;
	logic ar_fire;
	logic wr_fire;
	logic ctrl_rd;
	logic eval;
	logic match;

	// time-of-day set-point legality under the current number format
	function automatic logic tod_ok(input logic [7:0] v, input logic bcd, input logic [3:0] tens_max,
			input logic [7:0] bin_max);
		if (bcd) begin
			tod_ok = (v[7:4] <= tens_max) && (v[3:0] <= rtcac_pkg::BCD_ONES_MAX);
		end else begin
			tod_ok = (v <= bin_max);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// comparator

	assign set_pts = '{wday: {4'h0, s_q.alm_wday}, hour: s_q.alm_hour, min: s_q.alm_min, sec: s_q.alm_sec};

	rtcac_alarm_match u_match (
		.i_set(set_pts),
		.i_count(I_COUNT),
		.i_enable(s_q.field_en),
		.o_match(match)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bus handshakes

	// one write in flight: address and data are held until the response is taken
	assign aw_rdy = !s_q.aw_have && !s_q.bvalid;
	assign w_rdy = !s_q.w_have && !s_q.bvalid;
	assign ar_rdy = !s_q.rvalid;
	assign ar_fire = I_ARVALID && ar_rdy;
	assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
	assign ctrl_rd = ar_fire && (I_ARADDR == rtcac_pkg::ADDR_CONTROL);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		eval = 1'h0;
		s_d.presc_clr = 1'h0;
		if (I_AWVALID && aw_rdy) begin
			s_d.aw_have = 1'h1;
			s_d.aw_addr = I_AWADDR;
		end
		if (I_WVALID && w_rdy) begin
			s_d.w_have = 1'h1;
			s_d.w_data = I_WDATA[7:0];
			s_d.w_strb0 = I_WSTRB[0];
		end
		if (s_q.bvalid && I_BREADY) begin
			s_d.bvalid = 1'h0;
		end
		if (s_q.rvalid && I_RREADY) begin
			s_d.rvalid = 1'h0;
		end
		// wake cause is caught once, on the first edge after reset release
		if (!s_q.woke_taken) begin
			s_d.woke = I_WAKE_BY_ALARM;
			s_d.woke_taken = 1'h1;
		end
		if (ar_fire) begin
			s_d.rvalid = 1'h1;
			s_d.rresp = rtcac_pkg::RESP_OKAY;
			unique case (I_ARADDR)
				rtcac_pkg::ADDR_ALM_SECOND: s_d.rdata = s_q.alm_sec;
				rtcac_pkg::ADDR_ALM_MINUTE: s_d.rdata = s_q.alm_min;
				rtcac_pkg::ADDR_ALM_HOUR: s_d.rdata = s_q.alm_hour;
				rtcac_pkg::ADDR_ALM_WEEKDAY: s_d.rdata = {4'h0, s_q.alm_wday};
				rtcac_pkg::ADDR_FIELD_EN: s_d.rdata = {4'h0, s_q.field_en};
				rtcac_pkg::ADDR_CONTROL: s_d.rdata = {s_q.flag, s_q.ie, s_q.bcd, s_q.src_line,
						s_q.line_50, s_q.dst, s_q.woke, s_q.unlock};
				default: begin
					s_d.rdata = 8'h00;
					s_d.rresp = rtcac_pkg::RESP_DECERR;
				end
			endcase
		end
		if (ctrl_rd) begin
			s_d.flag = 1'h0;
			// a wake cause caught in this same cycle outlives the read
			if (s_q.woke_taken) begin
				s_d.woke = 1'h0;
			end
		end
		if (wr_fire) begin
			s_d.bvalid = 1'h1;
			s_d.bresp = rtcac_pkg::RESP_OKAY;
			s_d.aw_have = 1'h0;
			s_d.w_have = 1'h0;
			unique case (s_q.aw_addr)
				rtcac_pkg::ADDR_ALM_SECOND: begin
					// out-of-range values are dropped so the set-point stays a real time
					if (s_q.w_strb0 && tod_ok(s_q.w_data, s_q.bcd, rtcac_pkg::BCD_TENS_MAX_MINSEC,
							rtcac_pkg::BIN_MAX_MINSEC)) begin
						s_d.alm_sec = s_q.w_data;
					end
				end
				rtcac_pkg::ADDR_ALM_MINUTE: begin
					if (s_q.w_strb0 && tod_ok(s_q.w_data, s_q.bcd, rtcac_pkg::BCD_TENS_MAX_MINSEC,
							rtcac_pkg::BIN_MAX_MINSEC)) begin
						s_d.alm_min = s_q.w_data;
					end
				end
				rtcac_pkg::ADDR_ALM_HOUR: begin
					if (s_q.w_strb0 && tod_ok(s_q.w_data, s_q.bcd, rtcac_pkg::BCD_TENS_MAX_HOUR,
							rtcac_pkg::BIN_MAX_HOUR)) begin
						s_d.alm_hour = s_q.w_data;
					end
				end
				rtcac_pkg::ADDR_ALM_WEEKDAY: begin
					// only the low nibble is kept, whatever software puts above it
					if (s_q.w_strb0 && s_q.unlock && (s_q.w_data[3:0] >= rtcac_pkg::WDAY_MIN)
							&& (s_q.w_data[3:0] <= rtcac_pkg::WDAY_MAX)) begin
						s_d.alm_wday = s_q.w_data[3:0];
					end
				end
				rtcac_pkg::ADDR_FIELD_EN: begin
					if (s_q.w_strb0) begin
						s_d.field_en = s_q.w_data[3:0];
					end
				end
				rtcac_pkg::ADDR_CONTROL: begin
					if (s_q.w_strb0) begin
						s_d.ie = s_q.w_data[rtcac_pkg::CTL_IE];
						s_d.bcd = s_q.w_data[rtcac_pkg::CTL_BCD];
						s_d.src_line = s_q.w_data[rtcac_pkg::CTL_SRC];
						s_d.line_50 = s_q.w_data[rtcac_pkg::CTL_LINE];
						s_d.dst = s_q.w_data[rtcac_pkg::CTL_DST];
						s_d.unlock = s_q.w_data[rtcac_pkg::CTL_UNLOCK];
						s_d.presc_clr = 1'h1;
						eval = s_q.unlock && !s_q.w_data[rtcac_pkg::CTL_UNLOCK];
					end
				end
				default: s_d.bresp = rtcac_pkg::RESP_DECERR;
			endcase
		end
		if (I_COUNT_TICK) begin
			eval = 1'h1;
		end
		// a match in the cycle of a clearing read wins, so no alarm is lost
		if (eval && match) begin
			s_d.flag = 1'h1;
		end
		s_d.irq = s_d.flag && s_d.ie;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// set-points, flag and format/source bits are left out of the reset on purpose
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			s_q.aw_have <= 1'h0;
			s_q.aw_addr <= '0;
			s_q.w_have <= 1'h0;
			s_q.w_data <= 8'h00;
			s_q.w_strb0 <= 1'h0;
			s_q.bvalid <= 1'h0;
			s_q.bresp <= rtcac_pkg::RESP_OKAY;
			s_q.rvalid <= 1'h0;
			s_q.rresp <= rtcac_pkg::RESP_OKAY;
			s_q.rdata <= 8'h00;
			s_q.field_en <= rtcac_pkg::RST_FIELD_EN;
			s_q.ie <= rtcac_pkg::RST_IE;
			s_q.woke <= 1'h0;
			s_q.woke_taken <= 1'h0;
			s_q.unlock <= rtcac_pkg::RST_UNLOCK;
			s_q.presc_clr <= 1'h0;
			s_q.irq <= 1'h0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign O_AWREADY = aw_rdy;
	assign O_WREADY = w_rdy;
	assign O_ARREADY = ar_rdy;
	assign O_BVALID = s_q.bvalid;
	assign O_BRESP = s_q.bresp;
	assign O_RVALID = s_q.rvalid;
	assign O_RRESP = s_q.rresp;
	assign O_RDATA = {24'h000000, s_q.rdata};
	assign O_ALARM_IRQ = s_q.irq;
	assign O_PRESCALER_CLEAR = s_q.presc_clr;
	assign O_OSC_ENABLE = !s_q.src_line;
	assign O_LINE_SOURCE = s_q.src_line;
	assign O_PRESCALE_DIVISOR = !s_q.src_line ? rtcac_pkg::DIV_XTAL
			: (s_q.line_50 ? rtcac_pkg::DIV_LINE_50 : rtcac_pkg::DIV_LINE_60);
	assign O_BCD_MODE = s_q.bcd;
	assign O_COUNTER_RUN = !s_q.unlock;
	assign O_COUNT_WRITE_ENABLE = s_q.unlock;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);

	property p_read_clears;
		ctrl_rd && !(eval && match) |=> !s_q.flag && !O_ALARM_IRQ && !(s_q.woke && $past(s_q.woke_taken));
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("control read left flag or woke set");

	property p_flag_rise_cause;
		$rose(s_q.flag) |-> $past(eval) && $past(match);
	endproperty
	a_flag_rise_cause: assert property (p_flag_rise_cause) else $error("alarm flag rose without evaluation");

	property p_irq_gate;
		O_ALARM_IRQ == (s_q.flag && s_q.ie);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt not equal to gated flag");

	property p_irq_needs_enable;
		!s_q.ie |-> !O_ALARM_IRQ;
	endproperty
	a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("interrupt with enable low");

	property p_wday_locked;
		wr_fire && (s_q.aw_addr == rtcac_pkg::ADDR_ALM_WEEKDAY) && !s_q.unlock |=> $stable(s_q.alm_wday);
	endproperty
	a_wday_locked: assert property (p_wday_locked) else $error("weekday set-point changed while locked");

	property p_presc_clear;
		wr_fire && (s_q.aw_addr == rtcac_pkg::ADDR_CONTROL) && s_q.w_strb0 |=> O_PRESCALER_CLEAR ##1 !O_PRESCALER_CLEAR;
	endproperty
	a_presc_clear: assert property (p_presc_clear) else $error("prescaler clear not one cycle after write");

	property p_xtal_div;
		!O_LINE_SOURCE |-> O_OSC_ENABLE && (O_PRESCALE_DIVISOR == 16'h8000);
	endproperty
	a_xtal_div: assert property (p_xtal_div) else $error("crystal mode divisor or oscillator wrong");

	property p_line_div;
		O_LINE_SOURCE |-> !O_OSC_ENABLE && (O_PRESCALE_DIVISOR == (s_q.line_50 ? 16'h0032 : 16'h003C));
	endproperty
	a_line_div: assert property (p_line_div) else $error("line mode divisor wrong");

	property p_hour_illegal;
		wr_fire && (s_q.aw_addr == rtcac_pkg::ADDR_ALM_HOUR) && !s_q.bcd && (s_q.w_data > 8'h17)
				|=> $stable(s_q.alm_hour);
	endproperty
	a_hour_illegal: assert property (p_hour_illegal) else $error("illegal binary hour accepted");

	property p_unlock_halts;
		wr_fire && (s_q.aw_addr == rtcac_pkg::ADDR_CONTROL) && s_q.w_strb0 && s_q.w_data[0]
				|=> !O_COUNTER_RUN && O_COUNT_WRITE_ENABLE;
	endproperty
	a_unlock_halts: assert property (p_unlock_halts) else $error("unlock did not halt counter");

	property p_wday_range;
		wr_fire && (s_q.aw_addr == rtcac_pkg::ADDR_ALM_WEEKDAY)
				&& ((s_q.w_data[3:0] < rtcac_pkg::WDAY_MIN) || (s_q.w_data[3:0] > rtcac_pkg::WDAY_MAX))
				|=> $stable(s_q.alm_wday);
	endproperty
	a_wday_range: assert property (p_wday_range) else $error("weekday outside 1 to 7 accepted");

	property p_sec_illegal;
		wr_fire && (s_q.aw_addr == rtcac_pkg::ADDR_ALM_SECOND) && !s_q.bcd && (s_q.w_data > 8'h3B)
				|=> $stable(s_q.alm_sec);
	endproperty
	a_sec_illegal: assert property (p_sec_illegal) else $error("illegal binary second accepted");

	property p_irq_held;
		O_ALARM_IRQ && !ctrl_rd && !wr_fire |=> O_ALARM_IRQ;
	endproperty
	a_irq_held: assert property (p_irq_held) else $error("interrupt dropped without control read");

	c_alarm_flag: cover property ($rose(s_q.flag));
	c_ctrl_read_clear: cover property (s_q.flag ##1 ctrl_rd ##1 !s_q.flag);
	c_wday_write: cover property (wr_fire && (s_q.aw_addr == rtcac_pkg::ADDR_ALM_WEEKDAY) && s_q.unlock);
	c_relock_eval: cover property (eval && match && !I_COUNT_TICK);

endmodule

// ==== core/rtcac_alarm_match.sv ====
// alarm comparator: enabled set-point fields against the current counts
// assumes counts and set-points are in the same number format
module rtcac_alarm_match (
	input wire rtcac_pkg::rtcac_count_t i_set,
	input wire rtcac_pkg::rtcac_count_t i_count,
	input wire logic [3:0] i_enable,
	output logic o_match
);

	logic [3:0][7:0] set_a;
	logic [3:0][7:0] cnt_a;
	logic [3:0] field_ok;

	assign set_a = i_set;
	assign cnt_a = i_count;

	for (genvar g = 0; g < 4; g++) begin : g_field
		// a disabled field never blocks the match
		assign field_ok[g] = !i_enable[g] || (set_a[g] == cnt_a[g]);
	end

	// with nothing enabled the alarm would fire on every tick, so it stays silent
	assign o_match = (&field_ok) && (|i_enable);

endmodule

// ==== core/rtcac_pkg.sv ====
// constants, register map and carrier types of the clock alarm and control block
// assumes a 32-bit axi4-lite register bus and an outside count chain that supplies counts and ticks
package rtcac_pkg;

	localparam int ADDR_W = 12;

	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_ALM_SECOND = 8'hE8;
	localparam logic [7:0] IDX_ALM_MINUTE = 8'hE9;
	localparam logic [7:0] IDX_ALM_HOUR = 8'hEA;
	localparam logic [7:0] IDX_ALM_WEEKDAY = 8'hEB;
	localparam logic [7:0] IDX_FIELD_EN = 8'hEC;
	localparam logic [7:0] IDX_CONTROL = 8'hED;

	localparam logic [ADDR_W-1:0] ADDR_ALM_SECOND = {2'h0, IDX_ALM_SECOND, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_ALM_MINUTE = {2'h0, IDX_ALM_MINUTE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_ALM_HOUR = {2'h0, IDX_ALM_HOUR, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_ALM_WEEKDAY = {2'h0, IDX_ALM_WEEKDAY, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_FIELD_EN = {2'h0, IDX_FIELD_EN, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};

	// control register bit positions
	localparam int CTL_ALARM = 7;
	localparam int CTL_IE = 6;
	localparam int CTL_BCD = 5;
	localparam int CTL_SRC = 4;
	localparam int CTL_LINE = 3;
	localparam int CTL_DST = 2;
	localparam int CTL_WOKE = 1;
	localparam int CTL_UNLOCK = 0;

	// set-point limits
	localparam logic [7:0] BIN_MAX_HOUR = 8'h17;
	localparam logic [7:0] BIN_MAX_MINSEC = 8'h3B;
	localparam logic [3:0] BCD_TENS_MAX_HOUR = 4'h2;
	localparam logic [3:0] BCD_TENS_MAX_MINSEC = 4'h5;
	localparam logic [3:0] BCD_ONES_MAX = 4'h9;
	localparam logic [3:0] WDAY_MIN = 4'h1;
	localparam logic [3:0] WDAY_MAX = 4'h7;

	// prescale values per clock source
	localparam logic [15:0] DIV_XTAL = 16'h8000;
	localparam logic [15:0] DIV_LINE_60 = 16'h003C;
	localparam logic [15:0] DIV_LINE_50 = 16'h0032;

	// reset values
	localparam logic [3:0] RST_FIELD_EN = 4'h0;
	localparam logic RST_IE = 1'h0;
	localparam logic RST_UNLOCK = 1'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// field order matches the enable bits: weekday 3, hour 2, minute 1, second 0
	typedef struct packed {
		logic [7:0] wday;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} rtcac_count_t;

	typedef struct packed {
		logic aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [7:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [7:0] alm_sec;
		logic [7:0] alm_min;
		logic [7:0] alm_hour;
		logic [3:0] alm_wday;
		logic [3:0] field_en;
		logic flag;
		logic ie;
		logic bcd;
		logic src_line;
		logic line_50;
		logic dst;
		logic woke;
		logic woke_taken;
		logic unlock;
		logic presc_clr;
		logic irq;
	} rtcac_state_t;

endpackage
